// ==== rtl/nibble_cpu_defines.svh ====
// constants for the nibble cpu instruction decoder: opcodes, modifiers,
// register offsets, reset values and cycle counts
// assumes inclusion by bare name from the package and the core module
`ifndef NIBBLE_CPU_DEFINES_SVH
`define NIBBLE_CPU_DEFINES_SVH

// slots per instruction cycle, one system clock each
`define SLOTS_PER_CYCLE   8
`define STACK_LEVELS      3

// opcode nibbles
`define OP_COND_JUMP      4'h1
`define OP_PAIR           4'h2
`define OP_FETCH          4'h3
`define OP_JUMP_LONG      4'h4
`define OP_CALL           4'h5
`define OP_INC            4'h6
`define OP_BUMP           4'h7
`define OP_ADD            4'h8
`define OP_SUB            4'h9
`define OP_LOAD           4'hA
`define OP_SWAP           4'hB
`define OP_RETURN         4'hC
`define OP_LOAD_IMM       4'hD
`define OP_IO             4'hE
`define OP_ACC            4'hF

// memory and i/o modifiers that touch the accumulator arithmetically
`define IO_MINUS_RAM      4'h8
`define IO_PLUS_RAM       4'hB

// accumulator group modifiers
`define ACC_CLEAR_BOTH    4'h0
`define ACC_CLEAR_CARRY   4'h1
`define ACC_INCREMENT     4'h2
`define ACC_INVERT_CARRY  4'h3
`define ACC_INVERT_ACC    4'h4
`define ACC_ROTATE_LEFT   4'h5
`define ACC_ROTATE_RIGHT  4'h6
`define ACC_CARRY_TO_ACC  4'h7
`define ACC_DECREMENT     4'h8
`define ACC_CARRY_SUB     4'h9
`define ACC_SET_CARRY     4'hA
`define ACC_DECIMAL       4'hB
`define ACC_KEYPAD        4'hC
`define ACC_BANK_LINE     4'hD

// arithmetic constants
`define DECIMAL_LIMIT     4'h9
`define DECIMAL_FIX       4'h6
`define TCS_NO_CARRY      4'h9
`define TCS_CARRY         4'hA
`define KEYPAD_ERROR      4'hF

// register bus byte offsets
`define REG_CTRL          4'h0
`define REG_STATUS        4'h4
`define REG_PC            4'h8
`define REG_SRC           4'hC
`define CTRL_RUN_BIT      0
`define CTRL_RESET        1'b1

`endif

// ==== rtl/nibble_cpu_pkg.sv ====
// types for the nibble cpu instruction decoder
// assumes nibble_cpu_defines.svh is on the include path
package nibble_cpu_pkg;
  `include "nibble_cpu_defines.svh"

  typedef enum logic [2:0] {
    SLOT_A1, SLOT_A2, SLOT_A3, SLOT_M1, SLOT_M2, SLOT_X1, SLOT_X2, SLOT_X3
  } slot_type;

  typedef struct packed {
    logic [3:0] data;
    logic       data_oe;
    logic       sync;
    logic       prog_sel;
    logic [3:0] bank_sel;
  } nibble_out_type;

  typedef struct packed {
    slot_type                       slot;
    logic                           idle;
    logic                           second;
    logic [3:0]                     opc;
    logic [3:0]                     mod;
    logic [7:0]                     word2;
    logic [3:0]                     io_data;
    logic [11:0]                    pc;
    logic [`STACK_LEVELS-1:0][11:0] stk;
    logic [3:0]                     acc;
    logic                           carry;
    logic [15:0][3:0]               idx;
    logic [7:0]                     src;
    logic [1:0]                     bank;
    logic                           run;
    logic                           resp;
    logic [31:0]                    rdata;
    nibble_out_type                 bus;
  } state_type;
endpackage

// ==== rtl/nibble_cpu_instruction_decoder.sv ====
// nibble cpu core: fetch, decode and execute over the multiplexed nibble bus
// assumes nibble bus inputs synchronous to sys_clk_i, one slot per clock,
// and an avalon-mm master on the register port
//
// Operation
// RULE_01: a one-word instruction completes in one eight-slot instruction cycle.
// RULE_02: two-word instructions take two cycles; second word is address or data.
// RULE_03: opcode nibble comes in the first fetch slot, modifier in the second.
// RULE_04: conditional jump tests four bits, jumps in page to second word or skips.
// RULE_05: bit one inverts; others test acc zero, carry set, test input low.
// RULE_06: pair opcode with even modifier loads second word into selected pair.
// RULE_07: pair opcode with odd modifier sends pair as address in X2 and X3.
// RULE_08: fetch opcode, even modifier: read program byte at pair zero into pair.
// RULE_09: fetch opcode, odd modifier: jump to pair contents as low address.
// RULE_10: long jump goes to modifier nibble plus second-word byte.
// RULE_11: subroutine call pushes return address one level, then jumps.
// RULE_12: increment register; bump variant jumps in page when result nonzero.
// RULE_13: add register with carry; subtract register with borrow, updating carry.
// RULE_14: copy register to acc; swap register with acc.
// RULE_15: return pops stack and loads modifier; immediate load sets acc.
// RULE_16: sixteen 4-bit index registers, also eight pairs.
// RULE_17: each data ram chip holds four registers of twenty characters.
// RULE_18: memory and i/o ops act on the last sent pair address.
// RULE_19: i/o modifiers 0 to 7 write acc to ram, ports, program half, status.
// RULE_20: i/o modifiers 8 to 15 subtract, read, read port, add, read status.
// RULE_21: acc group 0 to 7: clear, clear carry, inc, invert, rotates, carry out.
// RULE_22: acc group 8 to 13: dec, carry subtract, set carry, bcd, keypad, bank.
// RULE_23: reset clears flags, status, program counter and all index registers.
// RULE_24: sync output marks the first slot of every instruction cycle.
// RULE_25: program select drives when program data is needed; bank selects for ram.
// RULE_26: decimal adjust adds six and sets carry when acc over nine or carry.
// RULE_27: bank line op picks the bank select output from low acc bits.
`timescale 1ns/10ps

module nibble_cpu_instruction_decoder (
  input  wire logic                           sys_clk_i,
  input  wire logic                           rst_i,
  input  wire logic [3:0]                     data_i,
  input  wire logic                           test_i,
  output nibble_cpu_pkg::nibble_out_type      nib_o,
  input  wire logic [3:0]                     avs_address_i,
  input  wire logic                           avs_read_i,
  input  wire logic                           avs_write_i,
  input  wire logic [31:0]                    avs_writedata_i,
  input  wire logic [3:0]                     avs_byteenable_i,
  output logic      [31:0]                    avs_readdata_o,
  output logic                                avs_waitrequest_o
);
  `include "nibble_cpu_defines.svh"

  nibble_cpu_pkg::state_type st;
  nibble_cpu_pkg::state_type next_st;
  logic                      req;
  logic [3:0]                rv;
  logic [4:0]                sum;
  logic                      cond;
  logic [11:0]               pc1;
  logic [11:0]               page_target;
  logic [3:0]                pair_hi;
  logic [3:0]                pair_lo;

  // instructions that need a second cycle
  function automatic logic two_word(input logic [3:0] opc, input logic [3:0] mod);
    two_word = (opc == `OP_COND_JUMP) || (opc == `OP_JUMP_LONG) ||
               (opc == `OP_CALL) || (opc == `OP_BUMP) ||
               (opc == `OP_PAIR && !mod[0]) || (opc == `OP_FETCH && !mod[0]);
  endfunction

  // bus outputs seen during the slot that state s stands in
  function automatic nibble_cpu_pkg::nibble_out_type drive(input nibble_cpu_pkg::state_type s);
    nibble_cpu_pkg::nibble_out_type o;
    logic [11:0]                    addr;
    logic [3:0]                     bank_hot;
    o        = '0;
    bank_hot = 4'h1 << s.bank;
    // indirect fetch puts pair zero on the low address
    addr     = (s.second && s.opc == `OP_FETCH) ? {s.pc[11:8], s.idx[0], s.idx[1]} : s.pc; // RULE_08
    if (!s.idle)
    begin
      unique case (s.slot)
        nibble_cpu_pkg::SLOT_A1:
        begin
          o.sync    = 1'b1; // RULE_24
          o.data    = addr[3:0];
          o.data_oe = 1'b1;
        end
        nibble_cpu_pkg::SLOT_A2:
        begin
          o.data    = addr[7:4];
          o.data_oe = 1'b1;
        end
        nibble_cpu_pkg::SLOT_A3:
        begin
          o.data     = addr[11:8];
          o.data_oe  = 1'b1;
          o.prog_sel = 1'b1; // RULE_25
        end
        nibble_cpu_pkg::SLOT_M2:
        begin
          // i/o ops tell the selected chips to decode the modifier
          if (!s.second && s.opc == `OP_IO)
          begin
            o.prog_sel = 1'b1; // RULE_25
            o.bank_sel = bank_hot; // RULE_27
          end
        end
        nibble_cpu_pkg::SLOT_X2:
        begin
          if (!s.second && s.opc == `OP_PAIR && s.mod[0])
          begin
            o.data     = s.idx[{s.mod[3:1], 1'b0}]; // RULE_07
            o.data_oe  = 1'b1;
            o.prog_sel = 1'b1;
            o.bank_sel = bank_hot;
          end
          else if (!s.second && s.opc == `OP_IO && !s.mod[3])
          begin
            o.data    = s.acc; // RULE_19
            o.data_oe = 1'b1;
          end
        end
        nibble_cpu_pkg::SLOT_X3:
        begin
          if (!s.second && s.opc == `OP_PAIR && s.mod[0])
          begin
            o.data    = s.idx[{s.mod[3:1], 1'b1}]; // RULE_07
            o.data_oe = 1'b1;
          end
        end
        default: ;
      endcase
    end
    drive = o;
  endfunction

  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~st.resp;
  assign avs_readdata_o    = st.rdata;
  assign nib_o             = st.bus;

  always_comb
  begin
    next_st     = st;
    rv          = st.idx[st.mod];
    pc1         = st.pc + 12'h001;
    page_target = {pc1[11:8], st.word2};
    pair_hi     = st.idx[{st.mod[3:1], 1'b0}];
    pair_lo     = st.idx[{st.mod[3:1], 1'b1}];
    sum         = 5'h00;
    cond        = 1'b0;

    // register bus: answer one cycle after the request is seen
    next_st.resp = req & ~st.resp;
    if (avs_read_i && !st.resp)
    begin
      unique case (avs_address_i)
        `REG_CTRL:   next_st.rdata = {31'h0000_0000, st.run};
        `REG_STATUS: next_st.rdata = {24'h00_0000, st.bank, st.idle, st.carry, st.acc};
        `REG_PC:     next_st.rdata = {20'h0_0000, st.pc};
        `REG_SRC:    next_st.rdata = {24'h00_0000, st.src};
        default:     next_st.rdata = 32'h0000_0000;
      endcase
    end
    if (avs_write_i && st.resp && avs_address_i == `REG_CTRL && avs_byteenable_i[0])
      next_st.run = avs_writedata_i[`CTRL_RUN_BIT];

    if (st.idle)
      next_st.idle = ~st.run;
    else
    begin
      next_st.slot = nibble_cpu_pkg::slot_type'(st.slot + 3'h1); // RULE_01
      unique case (st.slot)
        nibble_cpu_pkg::SLOT_M1:
        begin
          if (st.second)
            next_st.word2[7:4] = data_i; // RULE_02
          else
            next_st.opc = data_i; // RULE_03
        end
        nibble_cpu_pkg::SLOT_M2:
        begin
          if (st.second)
            next_st.word2[3:0] = data_i;
          else
            next_st.mod = data_i; // RULE_03
        end
        nibble_cpu_pkg::SLOT_X2: next_st.io_data = data_i; // RULE_20
        nibble_cpu_pkg::SLOT_X3:
        begin
          next_st.idle = ~st.run;
          if (!st.second && two_word(st.opc, st.mod))
          begin
            next_st.second = 1'b1; // RULE_02
            next_st.pc     = pc1;
          end
          else
          begin
            next_st.second = 1'b0;
            next_st.pc     = pc1;
            unique case (st.opc)
              `OP_COND_JUMP:
              begin
                cond = (st.mod[2] && st.acc == 4'h0) || (st.mod[1] && st.carry) ||
                       (st.mod[0] && !test_i); // RULE_05
                if (cond ^ st.mod[3])
                  next_st.pc = page_target; // RULE_04
              end
              `OP_PAIR:
              begin
                if (st.mod[0])
                  next_st.src = {pair_hi, pair_lo}; // RULE_18
                else
                begin
                  next_st.idx[{st.mod[3:1], 1'b0}] = st.word2[7:4]; // RULE_06
                  next_st.idx[{st.mod[3:1], 1'b1}] = st.word2[3:0];
                end
              end
              `OP_FETCH:
              begin
                if (st.mod[0])
                  next_st.pc = {pc1[11:8], pair_hi, pair_lo}; // RULE_09
                else
                begin
                  next_st.idx[{st.mod[3:1], 1'b0}] = st.word2[7:4]; // RULE_08
                  next_st.idx[{st.mod[3:1], 1'b1}] = st.word2[3:0];
                  next_st.pc                      = st.pc;
                end
              end
              `OP_JUMP_LONG: next_st.pc = {st.mod, st.word2}; // RULE_10
              `OP_CALL:
              begin
                next_st.stk = {st.stk[`STACK_LEVELS-2:0], pc1}; // RULE_11
                next_st.pc  = {st.mod, st.word2};
              end
              `OP_INC: next_st.idx[st.mod] = rv + 4'h1; // RULE_12
              `OP_BUMP:
              begin
                next_st.idx[st.mod] = rv + 4'h1; // RULE_12
                if (rv != 4'hF)
                  next_st.pc = page_target;
              end
              `OP_ADD:
              begin
                sum = {1'b0, st.acc} + {1'b0, rv} + {4'h0, st.carry}; // RULE_13
                {next_st.carry, next_st.acc} = sum;
              end
              `OP_SUB:
              begin
                sum = {1'b0, st.acc} + {1'b0, ~rv} + {4'h0, ~st.carry}; // RULE_13
                {next_st.carry, next_st.acc} = sum;
              end
              `OP_LOAD: next_st.acc = rv; // RULE_14
              `OP_SWAP:
              begin
                next_st.acc         = rv; // RULE_14
                next_st.idx[st.mod] = st.acc;
              end
              `OP_RETURN:
              begin
                next_st.pc  = st.stk[0]; // RULE_15
                next_st.stk = {12'h000, st.stk[`STACK_LEVELS-1:1]};
                next_st.acc = st.mod;
              end
              `OP_LOAD_IMM: next_st.acc = st.mod; // RULE_15
              `OP_IO:
              begin
                // writes leave on the bus at X2; reads land here
                if (st.mod == `IO_MINUS_RAM)
                begin
                  sum = {1'b0, st.acc} + {1'b0, ~st.io_data} + {4'h0, ~st.carry}; // RULE_20
                  {next_st.carry, next_st.acc} = sum;
                end
                else if (st.mod == `IO_PLUS_RAM)
                begin
                  sum = {1'b0, st.acc} + {1'b0, st.io_data} + {4'h0, st.carry}; // RULE_20
                  {next_st.carry, next_st.acc} = sum;
                end
                else if (st.mod[3])
                  next_st.acc = st.io_data; // RULE_20
              end
              `OP_ACC:
              begin
                unique case (st.mod)
                  `ACC_CLEAR_BOTH:
                  begin
                    next_st.acc   = 4'h0; // RULE_21
                    next_st.carry = 1'b0;
                  end
                  `ACC_CLEAR_CARRY: next_st.carry = 1'b0; // RULE_21
                  `ACC_INCREMENT:
                  begin
                    sum = {1'b0, st.acc} + 5'h01; // RULE_21
                    {next_st.carry, next_st.acc} = sum;
                  end
                  `ACC_INVERT_CARRY: next_st.carry = ~st.carry; // RULE_21
                  `ACC_INVERT_ACC: next_st.acc = ~st.acc; // RULE_21
                  `ACC_ROTATE_LEFT: {next_st.carry, next_st.acc} = {st.acc, st.carry}; // RULE_21
                  `ACC_ROTATE_RIGHT: {next_st.acc, next_st.carry} = {st.carry, st.acc}; // RULE_21
                  `ACC_CARRY_TO_ACC:
                  begin
                    next_st.acc   = {3'h0, st.carry}; // RULE_21
                    next_st.carry = 1'b0;
                  end
                  `ACC_DECREMENT:
                  begin
                    next_st.acc   = st.acc - 4'h1; // RULE_22
                    next_st.carry = (st.acc != 4'h0);
                  end
                  `ACC_CARRY_SUB:
                  begin
                    next_st.acc   = st.carry ? `TCS_CARRY : `TCS_NO_CARRY; // RULE_22
                    next_st.carry = 1'b0;
                  end
                  `ACC_SET_CARRY: next_st.carry = 1'b1; // RULE_22
                  `ACC_DECIMAL:
                  begin
                    if (st.acc > `DECIMAL_LIMIT || st.carry)
                    begin
                      next_st.acc   = st.acc + `DECIMAL_FIX; // RULE_26
                      next_st.carry = 1'b1;
                    end
                  end
                  `ACC_KEYPAD:
                  begin
                    unique case (st.acc) // RULE_22
                      4'h0:    next_st.acc = 4'h0;
                      4'h1:    next_st.acc = 4'h1;
                      4'h2:    next_st.acc = 4'h2;
                      4'h4:    next_st.acc = 4'h3;
                      4'h8:    next_st.acc = 4'h4;
                      default: next_st.acc = `KEYPAD_ERROR;
                    endcase
                  end
                  `ACC_BANK_LINE: next_st.bank = st.acc[1:0]; // RULE_27
                  default: ;
                endcase
              end
              default: ;
            endcase
          end
        end
        default: ;
      endcase
    end

    next_st.bus = drive(next_st);

    if (rst_i)
    begin
      next_st      = '0; // RULE_23
      next_st.idle = 1'b1;
      next_st.run  = `CTRL_RESET;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    st <= next_st;
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  a_sync_spacing: assert property (nib_o.sync |=> (!nib_o.sync)[*7]) // RULE_01
    else $error("sync repeated within one instruction cycle");
  a_opcode_first: assert property ( // RULE_03
    (st.slot == nibble_cpu_pkg::SLOT_M2 && !st.idle && !st.second) |-> st.opc == $past(data_i))
    else $error("opcode not taken from first fetch slot");
  a_two_word_cycle: assert property ( // RULE_02
    (st.slot == nibble_cpu_pkg::SLOT_X3 && !st.idle && !st.second && two_word(st.opc, st.mod))
    |=> st.second && st.slot == nibble_cpu_pkg::SLOT_A1)
    else $error("two-word instruction did not enter second cycle");
  a_jump_long_target: assert property ( // RULE_10
    (st.slot == nibble_cpu_pkg::SLOT_X3 && !st.idle && st.second && st.opc == `OP_JUMP_LONG)
    |=> st.pc == {$past(st.mod), $past(st.word2)})
    else $error("long jump target wrong");
  a_call_push: assert property ( // RULE_11
    (st.slot == nibble_cpu_pkg::SLOT_X3 && !st.idle && st.second && st.opc == `OP_CALL)
    |=> st.stk[0] == $past(st.pc) + 12'h001)
    else $error("call did not push return address");
  a_cond_zero: assert property ( // RULE_04
    (st.slot == nibble_cpu_pkg::SLOT_X3 && !st.idle && st.second &&
     st.opc == `OP_COND_JUMP && st.mod == 4'h4 && st.acc == 4'h0)
    |=> st.pc[7:0] == $past(st.word2))
    else $error("conditional jump on zero accumulator not taken");
  a_src_drive: assert property ( // RULE_07
    (nib_o.data_oe && nib_o.bank_sel != 4'h0 && st.slot == nibble_cpu_pkg::SLOT_X2)
    |-> nib_o.data == st.idx[{st.mod[3:1], 1'b0}] ##1 nib_o.data == st.idx[{st.mod[3:1], 1'b1}])
    else $error("pair address not sent in X2 and X3");
  a_prog_select: assert property ( // RULE_25
    (st.slot == nibble_cpu_pkg::SLOT_A3 && !st.idle) |-> nib_o.prog_sel && nib_o.data_oe)
    else $error("program select missing in third address slot");
  a_bank_select: assert property ( // RULE_27
    (nib_o.bank_sel != 4'h0) |-> nib_o.bank_sel == (4'h1 << st.bank))
    else $error("bank select does not follow chosen bank");
  a_reset_clear: assert property ( // RULE_23
    @(posedge sys_clk_i) disable iff (1'b0)
    rst_i |=> st.pc == 12'h000 && st.acc == 4'h0 && !st.carry && st.idx == '0 && st.idle)
    else $error("reset did not clear processor state");
endmodule

// ==== verif/nib_mem_model.sv ====
// program rom and data ram model on the multiplexed nibble bus
// assumes the core registers nib_i and runs one slot per clock
`timescale 1ns/10ps
module nib_mem_model (
  input  wire logic                      clk_i,
  input  nibble_cpu_pkg::nibble_out_type nib_i,
  output logic [3:0]                     data_o
);
  logic [7:0] rom [256];
  logic [3:0] ram [16];
  logic [3:0] stat [4];
  logic [2:0] slot;
  logic [7:0] adr;
  logic [7:0] ins;
  logic [3:0] chr;
  logic       src;
  initial
  begin
    foreach (rom[i]) rom[i] = 8'h00;
    foreach (ram[i]) ram[i] = 4'h0;
    foreach (stat[i]) stat[i] = 4'h0;
    data_o = 4'h0;
    slot = 3'h0;
    chr = 4'h0;
    src = 1'b0;
  end
  // undriven slots toggle so the core never sees a stale nibble
  always @(posedge clk_i)
  begin
    slot <= nib_i.sync ? 3'h1 : slot + 3'h1;
    if (nib_i.sync) adr[3:0] <= nib_i.data;
    if (slot == 3'h1) adr[7:4] <= nib_i.data;
    if (slot == 3'h2) ins <= rom[adr];
    data_o <= (slot == 3'h2) ? rom[adr][7:4] : (slot == 3'h3) ? ins[3:0] :
              (slot == 3'h5 && ins[7:2] == 6'h3B) ? stat[ins[1:0]] :
              (slot == 3'h5) ? ram[chr] : ~data_o;
    if (slot == 3'h6 && ins[7:2] == 6'h39) stat[ins[1:0]] <= nib_i.data;
    if (slot == 3'h6) src <= nib_i.prog_sel;
    if (slot == 3'h6 && ins == 8'hE0) ram[chr] <= nib_i.data;
    if (slot == 3'h7 && src) chr <= nib_i.data;
  end
endmodule

// ==== verif/tb_top.sv ====
// self-checking bench: programs run from the memory model, results read over avalon
// assumes the core and nib_mem_model are compiled first
`timescale 1ns/10ps
module tb_top;
  logic                           sys_clk_i;
  logic                           rst_i;
  logic                           test_i;
  logic                           avs_read_i;
  logic                           avs_write_i;
  logic [3:0]                     avs_address_i;
  logic [3:0]                     data_i;
  logic [31:0]                    avs_writedata_i;
  logic [31:0]                    avs_readdata_o;
  logic                           avs_waitrequest_o;
  logic [31:0]                    rd;
  nibble_cpu_pkg::nibble_out_type nib_o;
  int                             n_fail;
  int                             n_compared;
  int                             n;
  logic [3:0]                     cc [5];
  logic                           ct [5];
  logic [7:0]                     ce [5];
  nibble_cpu_instruction_decoder nibble_cpu_instruction_decoder_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .data_i(data_i), .test_i(test_i), .nib_o(nib_o),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o));
  nib_mem_model nib_mem_model_inst (.clk_i(sys_clk_i), .nib_i(nib_o), .data_o(data_i));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic end_sim;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is seen low, released after that edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    do
    begin
      @(negedge sys_clk_i);
      k++;
    end
    while (avs_waitrequest_o !== 1'b0 && k < 20);
    if (avs_waitrequest_o !== 1'b0)
    begin
      n_fail++;
      end_sim();
    end
    rd = avs_readdata_o;
    @(posedge sys_clk_i);
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  // load program, reset, let it reach its closing self-jump, check status
  task automatic run(input logic [127:0] p, input logic t, input logic [7:0] exp);
    for (int i = 0; i < 16; i++) nib_mem_model_inst.rom[i] = p[127-8*i -: 8];
    test_i <= t;
    rst_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (256) @(posedge sys_clk_i);
    bus(1'b0, 4'h4, 32'h0000_0000);
    chk(rd, {24'h00_0000, exp});
  endtask
  initial
  begin
    rst_i = 1'b1;
    test_i = 1'b1;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 4'h0;
    avs_writedata_i = 32'h0000_0000;
    n_fail = 0;
    n_compared = 0;
    cc = '{4'h2, 4'hA, 4'h4, 4'h1, 4'h1};
    ct = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    ce = '{8'h13, 8'h11, 8'h13, 8'h13, 8'h11};
    run(128'hD9F2_FB40_0300_0000_0000_0000_0000_0000, 1'b1, 8'h10);
    for (int i = 0; i < 5; i++)
      run({8'hFA, 4'h1, cc[i], 112'h06D1_4004_D340_0700_0000_0000_0000}, ct[i], ce[i]);
    run(128'h20A5_A181_B262_A292_4008_0000_0000_0000, 1'b1, 8'h10);
    run(128'h5005_4002_00C6_0000_0000_0000_0000_0000, 1'b1, 8'h06);
    run(128'hD5F4_F6F3_F5F8_F7FC_F2FC_FAF9_FAFD_400E, 1'b1, 8'h9A);
    run(128'h2000_21D5_E5D0_ED40_0700_0000_0000_0000, 1'b1, 8'h05);
    run(128'h2003_21D7_E0D0_E9F2_EB40_0900_0000_0000, 1'b1, 8'h0F);
    bus(1'b1, 4'h0, 32'h0000_0000);
    repeat (40) @(posedge sys_clk_i);
    bus(1'b0, 4'h4, 32'h0000_0000);
    chk(rd, 32'h0000_002F);
    bus(1'b0, 4'h2, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    bus(1'b1, 4'h0, 32'h0000_0001);
    n = 0;
    while (nib_o.sync !== 1'b1 && n < 40)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    @(negedge sys_clk_i);
    n = 1;
    while (nib_o.sync !== 1'b1 && n < 40)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    chk(n, 32'h0000_0008);
    end_sim();
  end
endmodule
